/* ppoc_params.svh */
`ifndef PPOC_PARAMS_SVH
`define PPOC_PARAMS_SVH
`define PPOC_NUM_PORTS 2
`define PPOC_CLK_HZ 50000000
`define PPOC_T_SINGLE_MS 5
`define PPOC_T_DOUBLE_MS 20
// both times use the clock rate in whole kHz, rounding down
`define PPOC_SINGLE_CYC ((`PPOC_T_SINGLE_MS * (`PPOC_CLK_HZ / 1000)))
`define PPOC_DOUBLE_CYC ((`PPOC_T_DOUBLE_MS * (`PPOC_CLK_HZ / 1000)))
`define PPOC_CNT_W 20
`define PPOC_MODE_SHARED 1'b0
`define PPOC_MODE_PERPORT 1'b1
`endif

/* ppoc_pkg.sv */
package ppoc_pkg;
    typedef logic [19:0] ppoc_cnt_t;
    typedef logic [1:0] ppoc_ports_t;
    typedef enum logic [1:0] {
        PPOC_OFF = 2'b00,
        PPOC_ON = 2'b01,
        PPOC_FAULT = 2'b10
    } ppoc_state_t;
endpackage : ppoc_pkg

/* ppoc_det_if.sv */
interface ppoc_det_if;
    logic enable;
    logic sample_low;
    logic clear;
    logic fault;
    modport ctl (output enable, output sample_low, output clear, input fault);
    modport det (input enable, input sample_low, input clear, output fault);
endinterface : ppoc_det_if

/* ppoc_detect.sv */
`include "ppoc_params.svh"
module ppoc_detect (
    input wire logic clk,
    input wire logic rst_n,
    ppoc_det_if.det dif
);
    import ppoc_pkg::*;
    localparam ppoc_cnt_t SINGLE_CYC = ppoc_cnt_t'(`PPOC_SINGLE_CYC);
    localparam ppoc_cnt_t DOUBLE_CYC = ppoc_cnt_t'(`PPOC_DOUBLE_CYC);
    ppoc_cnt_t low_q, low_d, win_q, win_d;
    logic prev_low_q, prev_low_d, armed_q, armed_d;
    logic fault_q, fault_d;
    logic new_group, set_fault;
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        new_group = dif.sample_low && !prev_low_q;
        set_fault = 1'b0;
        low_d = '0;
        win_d = win_q;
        armed_d = armed_q;
        prev_low_d = dif.sample_low;
        fault_d = fault_q;
        if (!dif.enable) begin
            win_d = '0;
            armed_d = 1'b0;
            prev_low_d = 1'b0;
        end else begin
            if (dif.sample_low && low_q != SINGLE_CYC) begin
                low_d = low_q + ppoc_cnt_t'(1);
            end else if (dif.sample_low) begin
                low_d = low_q;
            end
            if (low_d == SINGLE_CYC) begin
                set_fault = 1'b1;
            end
            if (armed_q) begin
                if (win_q == DOUBLE_CYC) begin
                    armed_d = 1'b0;
                end else begin
                    win_d = win_q + ppoc_cnt_t'(1);
                end
            end
            if (new_group) begin
                if (armed_q && win_q != DOUBLE_CYC) begin
                    set_fault = 1'b1;
                end
                armed_d = 1'b1;
                win_d = '0;
            end
        end
        // a new event wins over a clear in the same cycle
        if (set_fault) begin
            fault_d = 1'b1;
        end else if (dif.clear) begin
            fault_d = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_q <= '0;
            win_q <= '0;
            armed_q <= 1'b0;
            prev_low_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            low_q <= low_d;
            win_q <= win_d;
            armed_q <= armed_d;
            prev_low_q <= prev_low_d;
            fault_q <= fault_d;
        end
    end
    assign dif.fault = fault_q;
endmodule : ppoc_detect

/* ppoc_top.sv */
// Summary of operation
// - one pin per port for power and sense
// - hub logic or processor may control ports
// - shared or per-port configuration selectable
// - shared mode uses one common pin
// - per-port mode gives each port a pin
// - power off drives low, pull-up off
// - power on releases driver, pull-up on
// - short lows not filtered, each one starts a group
// - enabled port pin sampled continuously
// - low for 5 ms flags over-current
// - two low groups within 20 ms flag fault
// - per-port charging signalled on BC_ACTIVE, not on control pin
`include "ppoc_params.svh"
module ppoc_top (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic MODE_PERPORT,
    input wire logic PROC_CTL_SEL,
    input wire ppoc_pkg::ppoc_ports_t HUB_PWR_EN,
    input wire ppoc_pkg::ppoc_ports_t PROC_PWR_EN,
    input wire ppoc_pkg::ppoc_ports_t BC_EN,
    input wire ppoc_pkg::ppoc_ports_t OC_CLEAR,
    input wire ppoc_pkg::ppoc_ports_t PORT_CTL_PINS_IN,
    output ppoc_pkg::ppoc_ports_t PORT_CTL_PINS_OUT,
    output ppoc_pkg::ppoc_ports_t PORT_CTL_PINS_OE_N,
    output ppoc_pkg::ppoc_ports_t PORT_CTL_PULLUP_EN,
    output ppoc_pkg::ppoc_ports_t BC_ACTIVE,
    output ppoc_pkg::ppoc_ports_t OC_STATUS,
    output ppoc_pkg::ppoc_ports_t PORT_POWERED
);
    import ppoc_pkg::*;
    localparam int NP = `PPOC_NUM_PORTS;
    ppoc_ports_t req_en, pwr_q, pwr_d, oe_n_q, oe_n_d, pu_q, pu_d;
    ppoc_ports_t bc_q, bc_d, det_fault;
    ppoc_state_t st_q[NP], st_d[NP];
    ////////////////////////////////////////////////////////////////////
    function automatic logic shared_mode(input logic sel);
        shared_mode = (sel == `PPOC_MODE_SHARED);
    endfunction : shared_mode
    always_comb begin
        // processor override or autonomous hub control
        req_en = PROC_CTL_SEL ? PROC_PWR_EN : HUB_PWR_EN;
        if (shared_mode(MODE_PERPORT)) begin
            req_en = {NP{|req_en}};
        end
    end
    ////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_port
            ppoc_det_if dif ();
            logic pin_low;
            always_comb begin
                // shared mode senses port 0 pin only
                pin_low = shared_mode(MODE_PERPORT) ?
                    !PORT_CTL_PINS_IN[0] : !PORT_CTL_PINS_IN[g];
                dif.enable = (st_q[g] == PPOC_ON);
                dif.sample_low = pin_low;
                dif.clear = OC_CLEAR[g];
            end
            ppoc_detect u_det (
                .clk(MCLK),
                .rst_n(RESET_N),
                .dif(dif)
            );
            assign det_fault[g] = dif.fault;
            always_comb begin
                st_d[g] = st_q[g];
                case (st_q[g])
                    PPOC_OFF: if (req_en[g]) st_d[g] = PPOC_ON;
                    PPOC_ON: begin
                        if (det_fault[g]) st_d[g] = PPOC_FAULT;
                        else if (!req_en[g]) st_d[g] = PPOC_OFF;
                    end
                    PPOC_FAULT: if (!det_fault[g] && !req_en[g]) begin
                        st_d[g] = PPOC_OFF;
                    end
                    default: st_d[g] = PPOC_OFF;
                endcase
                pwr_d[g] = (st_d[g] == PPOC_ON);
                // off: drive low, pull-up off; on: release, pull-up on
                oe_n_d[g] = pwr_d[g];
                pu_d[g] = pwr_d[g];
                bc_d[g] = pwr_d[g] && BC_EN[g];
            end
            always_ff @(posedge MCLK) begin
                if (!RESET_N) begin
                    st_q[g] <= PPOC_OFF;
                    pwr_q[g] <= 1'b0;
                    oe_n_q[g] <= 1'b0;
                    pu_q[g] <= 1'b0;
                    bc_q[g] <= 1'b0;
                end else begin
                    st_q[g] <= st_d[g];
                    pwr_q[g] <= pwr_d[g];
                    oe_n_q[g] <= oe_n_d[g];
                    pu_q[g] <= pu_d[g];
                    bc_q[g] <= bc_d[g];
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////
    assign PORT_CTL_PINS_OUT = '0;
    assign PORT_CTL_PINS_OE_N = oe_n_q;
    assign PORT_CTL_PULLUP_EN = pu_q;
    assign BC_ACTIVE = bc_q;
    assign OC_STATUS = det_fault;
    assign PORT_POWERED = pwr_q;
endmodule : ppoc_top

/* ppoc_props.sv */
module ppoc_props (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic MODE_PERPORT,
    input wire logic PROC_CTL_SEL,
    input wire logic [1:0] HUB_PWR_EN,
    input wire logic [1:0] PROC_PWR_EN,
    input wire logic [1:0] OC_CLEAR,
    input wire logic [1:0] PORT_CTL_PINS_IN,
    input wire logic [1:0] PORT_CTL_PINS_OUT,
    input wire logic [1:0] PORT_CTL_PINS_OE_N,
    input wire logic [1:0] PORT_CTL_PULLUP_EN,
    input wire logic [1:0] BC_ACTIVE,
    input wire logic [1:0] OC_STATUS,
    input wire logic [1:0] PORT_POWERED
);
    timeunit 1ns;
    timeprecision 1ps;
    import ppoc_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    sequence s_grp; PORT_POWERED[0] && $fell(PORT_CTL_PINS_IN[0]); endsequence
    property p_drive; PORT_CTL_PINS_OE_N == PORT_POWERED &&
        PORT_CTL_PULLUP_EN == PORT_POWERED && PORT_CTL_PINS_OUT == 2'h0;
    endproperty
    a_drive: assert property (p_drive) else $error("pin drive");
    property p_bc; (BC_ACTIVE & ~PORT_POWERED) == 2'h0; endproperty
    a_bc: assert property (p_bc) else $error("charging");
    property p_reset; disable iff (1'b0) !RESET_N |=>
        PORT_POWERED == 2'h0 && OC_STATUS == 2'h0; endproperty
    a_reset: assert property (p_reset) else $error("reset");
    property p_on; MODE_PERPORT && !PROC_CTL_SEL && $rose(HUB_PWR_EN[0])
        && !OC_STATUS[0] |=> PORT_POWERED[0]; endproperty
    a_on: assert property (p_on) else $error("power on");
    property p_proc; MODE_PERPORT && PROC_CTL_SEL && !PROC_PWR_EN[1]
        |=> !PORT_POWERED[1]; endproperty
    a_proc: assert property (p_proc) else $error("processor");
    property p_shared; !MODE_PERPORT && !$past(MODE_PERPORT)
        |-> PORT_POWERED[0] == PORT_POWERED[1]; endproperty
    a_shared: assert property (p_shared) else $error("shared");
    property p_sticky; OC_STATUS[0] && !OC_CLEAR[0] |=> OC_STATUS[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky");
    property p_double; s_grp ##[1:40] s_grp |-> ##[1:2] OC_STATUS[0];
    endproperty
    a_double: assert property (p_double) else $error("double");
endmodule : ppoc_props

/* ppoc_switch_model.sv */
module ppoc_switch_model (
    input wire logic shared_pins,
    input wire ppoc_pkg::ppoc_ports_t oe_n,
    input wire ppoc_pkg::ppoc_ports_t pullup_en,
    input wire ppoc_pkg::ppoc_ports_t fault,
    output ppoc_pkg::ppoc_ports_t level
);
    timeunit 1ns;
    timeprecision 1ps;
    import ppoc_pkg::*;
    ppoc_ports_t raw;
    assign raw = oe_n & pullup_en & ~fault;
    // tied lines form one wired-and net
    assign level = shared_pins ? {2{&raw}} : raw;
endmodule : ppoc_switch_model

/* ppoc_top_bench.sv */
module ppoc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ppoc_pkg::*;
    logic MCLK = 0, RESET_N = 0, MODE_PERPORT = 1, PROC_CTL_SEL = 0, chk = 0;
    ppoc_ports_t HUB_PWR_EN = 0, PROC_PWR_EN = 0, BC_EN = 0, OC_CLEAR = 0;
    ppoc_ports_t oc = 0, PORT_CTL_PINS_IN, PORT_CTL_PINS_OUT;
    ppoc_ports_t PORT_CTL_PINS_OE_N, PORT_CTL_PULLUP_EN, BC_ACTIVE;
    ppoc_ports_t OC_STATUS, PORT_POWERED;
    logic [5:0] exp_q[$], ev, seen, pins;
    int errors = 0, num_checks = 0, cycles = 0, seed = 55616;
    ppoc_top i_dut (
        .MCLK(MCLK),
        .RESET_N(RESET_N),
        .MODE_PERPORT(MODE_PERPORT),
        .PROC_CTL_SEL(PROC_CTL_SEL),
        .HUB_PWR_EN(HUB_PWR_EN),
        .PROC_PWR_EN(PROC_PWR_EN),
        .BC_EN(BC_EN),
        .OC_CLEAR(OC_CLEAR),
        .PORT_CTL_PINS_IN(PORT_CTL_PINS_IN),
        .PORT_CTL_PINS_OUT(PORT_CTL_PINS_OUT),
        .PORT_CTL_PINS_OE_N(PORT_CTL_PINS_OE_N),
        .PORT_CTL_PULLUP_EN(PORT_CTL_PULLUP_EN),
        .BC_ACTIVE(BC_ACTIVE),
        .OC_STATUS(OC_STATUS),
        .PORT_POWERED(PORT_POWERED)
    );
    ppoc_switch_model i_sw (.shared_pins(!MODE_PERPORT),
        .oe_n(PORT_CTL_PINS_OE_N),
        .pullup_en(PORT_CTL_PULLUP_EN), .fault(oc), .level(PORT_CTL_PINS_IN));
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    task automatic complete_run();
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask : tick
    task automatic expect_st(input logic [5:0] v);
        exp_q.push_back(v);
        chk <= 1'b1;
        @(posedge MCLK);
        chk <= 1'b0;
    endtask : expect_st
    always @(negedge MCLK) begin
        cycles++;
        seen = {BC_ACTIVE, OC_STATUS, PORT_POWERED};
        if (chk) begin
            ev = exp_q.pop_front();
            num_checks++;
            if (seen !== ev) begin
                errors++;
                $display("[FAIL] status exp %h got %h", ev, seen);
            end
            num_checks++;
            pins = {PORT_CTL_PINS_OUT, PORT_CTL_PULLUP_EN, PORT_CTL_PINS_OE_N};
            if (pins !== {2'h0, ev[1:0], ev[1:0]}) begin
                errors++;
                $display("[FAIL] pin drive exp %h got %h",
                    {2'h0, ev[1:0], ev[1:0]}, pins);
            end
        end
        if (cycles > 500) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        tick(4);
        RESET_N <= 1'b1;
        expect_st(6'h00);
        for (int i = 0; i < 8; i++) begin
            HUB_PWR_EN <= 2'($random(seed));
            BC_EN <= 2'($random(seed));
            tick(2);
            expect_st({HUB_PWR_EN & BC_EN, 2'h0, HUB_PWR_EN});
        end
        PROC_CTL_SEL <= 1'b1;
        HUB_PWR_EN <= 2'h1;
        PROC_PWR_EN <= 2'h2;
        BC_EN <= 2'h0;
        tick(2);
        expect_st(6'h02);
        MODE_PERPORT <= 1'b0;
        PROC_CTL_SEL <= 1'b0;
        tick(2);
        expect_st(6'h03);
        MODE_PERPORT <= 1'b1;
        HUB_PWR_EN <= 2'h3;
        tick(2);
        oc <= 2'h1;
        tick(3);
        oc <= 2'h0;
        tick(5);
        expect_st(6'h03);
        oc <= 2'h1;
        tick(2);
        oc <= 2'h0;
        tick(3);
        expect_st(6'h06);
        OC_CLEAR <= 2'h1;
        tick(2);
        expect_st(6'h02);
        OC_CLEAR <= 2'h0;
        HUB_PWR_EN <= 2'h2;
        tick(2);
        HUB_PWR_EN <= 2'h3;
        tick(2);
        expect_st(6'h03);
        oc <= 2'h2;
        tick(2);
        oc <= 2'h0;
        tick(2);
        oc <= 2'h2;
        tick(2);
        oc <= 2'h0;
        tick(3);
        expect_st(6'h09);
        RESET_N <= 1'b0;
        tick(2);
        expect_st(6'h00);
        RESET_N <= 1'b1;
        tick(2);
        expect_st(6'h03);
        complete_run();
    end
endmodule : ppoc_top_bench
bind ppoc_top ppoc_props i_props (
    .MCLK(MCLK),
    .RESET_N(RESET_N),
    .MODE_PERPORT(MODE_PERPORT),
    .PROC_CTL_SEL(PROC_CTL_SEL),
    .HUB_PWR_EN(HUB_PWR_EN),
    .PROC_PWR_EN(PROC_PWR_EN),
    .OC_CLEAR(OC_CLEAR),
    .PORT_CTL_PINS_IN(PORT_CTL_PINS_IN),
    .PORT_CTL_PINS_OUT(PORT_CTL_PINS_OUT),
    .PORT_CTL_PINS_OE_N(PORT_CTL_PINS_OE_N),
    .PORT_CTL_PULLUP_EN(PORT_CTL_PULLUP_EN),
    .BC_ACTIVE(BC_ACTIVE),
    .OC_STATUS(OC_STATUS),
    .PORT_POWERED(PORT_POWERED)
);
